/* File: include/prescaled_timer_pkg.sv */
// register map, field layout, reset values and codes of the prescaled reload timer
package prescaled_timer_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h100;
  localparam logic [9:0] IDX_IOCTL = 10'h101;
  localparam logic [9:0] IDX_MODE = 10'h102;
  localparam logic [9:0] IDX_PRE = 10'h103;
  localparam logic [9:0] IDX_MAIN = 10'h104;
  localparam logic [9:0] IDX_ROUTE = 10'h105;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 10;
  // control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_STAT = 1;
  localparam int CTRL_HALT = 2;
  localparam int CTRL_EDGE = 4;
  localparam int CTRL_UNDF = 5;
  // mode register fields
  localparam int MODE_LSB = 0;
  localparam int SRC_LSB = 4;
  localparam int SRC_CUT = 7;
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_FIRST_BAD = 3'h5;
  // count source codes
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV8 = 3'h1;
  localparam logic [2:0] SRC_OSC = 3'h2;
  localparam logic [2:0] SRC_DIV2 = 3'h3;
  localparam logic [2:0] SRC_SUB32 = 3'h4;
  localparam logic [2:0] SRC_SUB = 3'h6;
  // pin routing codes
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_A = 2'h1;
  localparam logic [1:0] ROUTE_B = 2'h2;
  // reset values, divider last counts and the NONSEQ transfer code
  localparam logic [7:0] RST_CNT = 8'hFF;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [4:0] SUB32_LAST = 5'h1F;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* File: core/prescaled_timer.sv */
// prescaled reload timer, timer mode, with AHB-Lite register slave
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
module prescaled_timer #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata_q,
  output logic hreadyout_q,
  output logic hresp_q,
  // external count sources, synchronous levels
  input wire logic onchip_osc_clock,
  input wire logic subclock,
  // events and pins
  output logic timer_irq_q,
  output logic port_pin_a_route_q,
  output logic port_pin_b_route_q,
  output logic timer_io_pin_oe_q,
  output logic timer_inverted_out_pin_oe_q
);
  if (ADDR_W < prescaled_timer_pkg::IDX_W + prescaled_timer_pkg::IDX_LSB) begin : g_chk
    $error("ADDR_W too small for register map");
  end
  logic wr_pend_q, rd_pend_q;
  logic [9:0] dp_idx_q;
  logic run_q, stat_q, undf_q;
  logic [7:0] ioctl_q, mode_q;
  logic [1:0] route_q;
  logic [7:0] pre_rld_q, pre_cnt_q, main_rld_q, main_cnt_q;
  logic pre_pend_q, main_pend_q;
  logic [2:0] div_q;
  logic [4:0] sub32_q;
  logic osc_prev_q, sub_prev_q, src_tick_q;
  logic [7:0] wdata;
  logic wr_ctrl, wr_ioctl, wr_mode, wr_pre, wr_main, wr_route;
  logic halt_wr, stopped, cnt_tick, pre_uf, main_uf;
  logic osc_edge, sub_edge, sel_tick;
  logic [7:0] rdata;
  logic [2:0] src_sel;
  logic addr_ok;
  // bus address phase; data phase write uses the stored index
  assign addr_ok = hsel && hready && (htrans == prescaled_timer_pkg::HTRANS_NONSEQ);
  assign wdata = hwdata[7:0];
  assign wr_ctrl = wr_pend_q && (dp_idx_q == prescaled_timer_pkg::IDX_CTRL);
  assign wr_ioctl = wr_pend_q && (dp_idx_q == prescaled_timer_pkg::IDX_IOCTL);
  assign wr_mode = wr_pend_q && (dp_idx_q == prescaled_timer_pkg::IDX_MODE);
  assign wr_pre = wr_pend_q && (dp_idx_q == prescaled_timer_pkg::IDX_PRE);
  assign wr_main = wr_pend_q && (dp_idx_q == prescaled_timer_pkg::IDX_MAIN);
  assign wr_route = wr_pend_q && (dp_idx_q == prescaled_timer_pkg::IDX_ROUTE);
  assign halt_wr = wr_ctrl && wdata[prescaled_timer_pkg::CTRL_HALT];
  assign stopped = !run_q && !stat_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      dp_idx_q <= 10'h000;
    end else if (addr_ok) begin
      wr_pend_q <= hwrite;
      rd_pend_q <= !hwrite;
      dp_idx_q <= haddr[prescaled_timer_pkg::IDX_LSB +: prescaled_timer_pkg::IDX_W];
    end else begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end
  end
  // reads take one wait state so a write just before is already visible
  always_comb begin
    rdata = 8'h00;
    case (dp_idx_q)
      prescaled_timer_pkg::IDX_CTRL: begin
        rdata[prescaled_timer_pkg::CTRL_RUN] = run_q;
        rdata[prescaled_timer_pkg::CTRL_STAT] = stat_q;
        rdata[prescaled_timer_pkg::CTRL_UNDF] = undf_q; // halt bit reads zero
      end
      prescaled_timer_pkg::IDX_IOCTL: rdata = ioctl_q;
      prescaled_timer_pkg::IDX_MODE: rdata = mode_q;
      prescaled_timer_pkg::IDX_PRE: rdata = pre_cnt_q; // live value
      prescaled_timer_pkg::IDX_MAIN: rdata = main_cnt_q;
      prescaled_timer_pkg::IDX_ROUTE: rdata = {6'h00, route_q};
      default: rdata = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
      hreadyout_q <= !(addr_ok && !hwrite);
      if (rd_pend_q) begin
        hrdata_q <= {24'h000000, rdata};
      end
    end
  end
  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ioctl_q <= prescaled_timer_pkg::RST_REG;
      mode_q <= prescaled_timer_pkg::RST_REG;
      route_q <= prescaled_timer_pkg::ROUTE_NONE;
    end else begin
      if (wr_ioctl) begin
        ioctl_q <= wdata;
      end
      // prohibited mode codes leave the old mode in place
      if (wr_mode && (wdata[2:0] < prescaled_timer_pkg::MODE_FIRST_BAD)) begin
        mode_q <= {wdata[7:4], 1'b0, wdata[2:0]};
      end
      if (wr_route) begin
        route_q <= wdata[1:0]; // upper bits not stored
      end
    end
  end
  // count source dividers and edge detectors
  assign osc_edge = onchip_osc_clock && !osc_prev_q;
  assign sub_edge = subclock && !sub_prev_q;
  assign src_sel = mode_q[prescaled_timer_pkg::SRC_LSB +: 3];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 3'h0;
      sub32_q <= 5'h00;
      osc_prev_q <= 1'b0;
      sub_prev_q <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      osc_prev_q <= onchip_osc_clock;
      sub_prev_q <= subclock;
      if (sub_edge) begin
        sub32_q <= sub32_q + 5'h01;
      end
    end
  end

  always_comb begin
    case (src_sel)
      prescaled_timer_pkg::SRC_DIV1: sel_tick = 1'b1;
      prescaled_timer_pkg::SRC_DIV2: sel_tick = div_q[0];
      prescaled_timer_pkg::SRC_DIV8: sel_tick = (div_q == prescaled_timer_pkg::DIV8_LAST);
      prescaled_timer_pkg::SRC_OSC: sel_tick = osc_edge;
      prescaled_timer_pkg::SRC_SUB: sel_tick = sub_edge;
      prescaled_timer_pkg::SRC_SUB32:
        sel_tick = sub_edge && (sub32_q == prescaled_timer_pkg::SUB32_LAST);
      default: sel_tick = 1'b0;
    endcase
  end
  // cutoff bit gates the source; registered tick follows the source's edge one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_tick_q <= 1'b0;
    end else begin
      src_tick_q <= sel_tick && !mode_q[prescaled_timer_pkg::SRC_CUT]
        && (mode_q[2:0] == prescaled_timer_pkg::MODE_TIMER);
    end
  end
  // run bit and status flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 1'b0;
      stat_q <= 1'b0;
    end else if (halt_wr || (wr_ctrl && !wdata[prescaled_timer_pkg::CTRL_RUN])) begin
      run_q <= 1'b0;
      stat_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        run_q <= 1'b1;
      end
      if (run_q && src_tick_q) begin
        stat_q <= 1'b1;
      end
    end
  end
  assign cnt_tick = stat_q && src_tick_q;
  assign pre_uf = cnt_tick && !pre_pend_q && (pre_cnt_q == 8'h00);
  assign main_uf = pre_uf && !main_pend_q && (main_cnt_q == 8'h00);
  // prescaler stage; bus writes while counting are handed over at the next source tick, stopped writes load at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_rld_q <= prescaled_timer_pkg::RST_CNT;
      pre_cnt_q <= prescaled_timer_pkg::RST_CNT;
      pre_pend_q <= 1'b0;
    end else if (halt_wr) begin
      pre_rld_q <= prescaled_timer_pkg::RST_CNT;
      pre_cnt_q <= prescaled_timer_pkg::RST_CNT;
      pre_pend_q <= 1'b0;
    end else if (wr_pre) begin
      pre_rld_q <= wdata;
      if (stopped) begin
        pre_cnt_q <= wdata;
        pre_pend_q <= 1'b0;
      end else begin
        pre_pend_q <= 1'b1;
        // an underflow in the write cycle still reloads instead of wrapping to FF
        if (cnt_tick) begin
          pre_cnt_q <= (pre_cnt_q == 8'h00) ? pre_rld_q : pre_cnt_q - 8'h01;
        end
      end
    end else if (cnt_tick) begin
      if (pre_pend_q) begin
        pre_cnt_q <= pre_rld_q;
        pre_pend_q <= 1'b0;
      end else if (pre_cnt_q == 8'h00) begin
        pre_cnt_q <= pre_rld_q;
      end else begin
        pre_cnt_q <= pre_cnt_q - 8'h01;
      end
    end
  end
  // main stage steps on prescaler underflow only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_rld_q <= prescaled_timer_pkg::RST_CNT;
      main_cnt_q <= prescaled_timer_pkg::RST_CNT;
      main_pend_q <= 1'b0;
    end else if (halt_wr) begin
      main_rld_q <= prescaled_timer_pkg::RST_CNT;
      main_cnt_q <= prescaled_timer_pkg::RST_CNT;
      main_pend_q <= 1'b0;
    end else if (wr_main) begin
      main_rld_q <= wdata;
      if (stopped) begin
        main_cnt_q <= wdata;
        main_pend_q <= 1'b0;
      end else begin
        main_pend_q <= 1'b1;
        if (pre_uf) begin
          main_cnt_q <= (main_cnt_q == 8'h00) ? main_rld_q : main_cnt_q - 8'h01;
        end
      end
    end else if (pre_uf) begin
      if (main_pend_q) begin
        main_cnt_q <= main_rld_q;
        main_pend_q <= 1'b0;
      end else if (main_cnt_q == 8'h00) begin
        main_cnt_q <= main_rld_q;
      end else begin
        main_cnt_q <= main_cnt_q - 8'h01;
      end
    end
  end
  // underflow flag: hardware set wins over a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      undf_q <= 1'b0;
      timer_irq_q <= 1'b0;
    end else begin
      timer_irq_q <= main_uf;
      if (main_uf) begin
        undf_q <= 1'b1;
      end else if (wr_ctrl && !wdata[prescaled_timer_pkg::CTRL_UNDF]) begin
        undf_q <= 1'b0;
      end
    end
  end
  // pin routing; timer mode never drives the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_pin_a_route_q <= 1'b0;
      port_pin_b_route_q <= 1'b0;
      timer_io_pin_oe_q <= 1'b0;
      timer_inverted_out_pin_oe_q <= 1'b0;
    end else begin
      port_pin_a_route_q <= (route_q == prescaled_timer_pkg::ROUTE_A);
      port_pin_b_route_q <= (route_q == prescaled_timer_pkg::ROUTE_B);
      timer_io_pin_oe_q <= 1'b0;
      timer_inverted_out_pin_oe_q <= 1'b0;
    end
  end

  chk_route_decode: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 (port_pin_a_route_q == ($past(route_q) == 2'h1))
      && (port_pin_b_route_q == ($past(route_q) == 2'h2)))
    else $error("routing output does not match routing code");
  chk_route_upper: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_pend_q && dp_idx_q == prescaled_timer_pkg::IDX_ROUTE) |=> hrdata_q[7:2] == 6'h00)
    else $error("routing upper bits not zero");
  chk_pre_reload: assert property (@(posedge hclk) disable iff (!hresetn)
    (pre_uf && !halt_wr && !wr_pre) |=> pre_cnt_q == $past(pre_rld_q))
    else $error("prescaler did not reload on underflow");
  chk_irq_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    main_uf |=> timer_irq_q && undf_q)
    else $error("underflow without request and flag");
  chk_halt_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    halt_wr |=> (pre_cnt_q == 8'hFF) && (main_cnt_q == 8'hFF) && !run_q && !stat_q)
    else $error("halt did not reset timer");
  chk_flag_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (undf_q && !(wr_ctrl && !wdata[prescaled_timer_pkg::CTRL_UNDF])) |=> undf_q)
    else $error("underflow flag lost without zero write");
  chk_stopped_load: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pre && stopped) |=> pre_cnt_q == $past(wdata))
    else $error("stopped write did not load counter");
  chk_running_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pre && !stopped && !cnt_tick && !halt_wr) |=> $stable(pre_cnt_q))
    else $error("counter changed before sync event");
  chk_main_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (pre_uf && !main_pend_q && main_cnt_q != 8'h00 && !wr_main && !halt_wr)
      |=> main_cnt_q == $past(main_cnt_q) - 8'h01)
    else $error("main counter did not step on prescaler underflow");
  chk_run_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ctrl && wdata[0] && !wdata[2]) |=> run_q)
    else $error("run bit not set by write");
endmodule

/* File: sim/test_prescaled_timer.sv */
// self-checking testbench of the prescaled reload timer in timer mode
`timescale 1ns/1ps
module test_prescaled_timer;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hready;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic onchip_osc_clock = 1'b0;
  logic [1:0] sub_div_q = 2'h0;
  logic subclock;
  logic timer_irq_q;
  logic port_pin_a_route_q;
  logic port_pin_b_route_q;
  logic timer_io_pin_oe_q;
  logic timer_inverted_out_pin_oe_q;
  int num_errors = 0;
  int n_compared = 0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout_q;
  // subclock rises every 4 cycles, oscillator every 2
  assign subclock = sub_div_q[1];

  prescaled_timer i_prescaled_timer (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata_q, .hreadyout_q, .hresp_q, .onchip_osc_clock, .subclock, .timer_irq_q,
    .port_pin_a_route_q, .port_pin_b_route_q, .timer_io_pin_oe_q,
    .timer_inverted_out_pin_oe_q
  );

  initial begin
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    onchip_osc_clock <= ~onchip_osc_clock;
    sub_div_q <= sub_div_q + 2'h1;
  end

  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      num_errors++;
    end
  endtask

  // ready and data are registers, so the value before the edge is what the edge samples
  task automatic phase(output logic [7:0] rd);
    int n;
    logic rdy;
    logic rsp;
    n = 0;
    do begin
      @(negedge hclk);
      rdy = hready;
      rsp = hresp_q;
      rd = hrdata_q[7:0];
      @(posedge hclk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin
      $display("[ERR] %0t bus wait ran out", $time);
      num_errors++;
      stop_test();
    end
    chk({15'h0, rsp}, 16'h0, "response not okay");
  endtask

  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    hsel <= 1'b1;
    htrans <= prescaled_timer_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {idx, 2'b00};
    phase(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    phase(rd);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    logic [7:0] d;
    bus(1'b1, idx, v, d);
  endtask

  task automatic rchk(input logic [9:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    chk({8'h00, v}, {8'h00, exp}, what);
  endtask

  // cycles between two consecutive interrupt pulses, bounded
  task automatic irq_gap(output int gap);
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (timer_irq_q !== 1'b1 && n < 3000);
    gap = 0;
    do begin
      @(negedge hclk);
      gap++;
    end while (timer_irq_q !== 1'b1 && gap < 3000);
    @(posedge hclk);
    if (n >= 3000 || gap >= 3000) begin
      $display("[ERR] %0t no interrupt pulse", $time);
      num_errors++;
      stop_test();
    end
  endtask

  task automatic t_reset();
    rchk(prescaled_timer_pkg::IDX_CTRL, 8'h00, "ctrl reset");
    rchk(prescaled_timer_pkg::IDX_IOCTL, 8'h00, "ioctl reset");
    rchk(prescaled_timer_pkg::IDX_MODE, 8'h00, "mode reset");
    rchk(prescaled_timer_pkg::IDX_PRE, 8'hFF, "prescale reset");
    rchk(prescaled_timer_pkg::IDX_MAIN, 8'hFF, "main reset");
    rchk(prescaled_timer_pkg::IDX_ROUTE, 8'h00, "route reset");
    wr(10'h106, 8'hAA);
    rchk(10'h106, 8'h00, "unmapped read");
  endtask

  // routing set first, every code, upper bits written high must read zero
  task automatic t_route();
    for (int i = 0; i < 4; i++) begin
      wr(prescaled_timer_pkg::IDX_ROUTE, {3'h7, 3'h0, 2'(i)});
      rchk(prescaled_timer_pkg::IDX_ROUTE, {6'h00, 2'(i)}, "route readback");
      chk({15'h0, port_pin_a_route_q}, 16'(i == 1), "pin a route");
      chk({15'h0, port_pin_b_route_q}, 16'(i == 2), "pin b route");
    end
    wr(prescaled_timer_pkg::IDX_ROUTE, 8'h00);
    wr(prescaled_timer_pkg::IDX_IOCTL, 8'h06);
    rchk(prescaled_timer_pkg::IDX_IOCTL, 8'h06, "ioctl readback");
    chk({14'h0, timer_io_pin_oe_q, timer_inverted_out_pin_oe_q}, 16'h0, "pins idle");
  endtask

  task automatic t_mode();
    wr(prescaled_timer_pkg::IDX_MODE, 8'h68);
    rchk(prescaled_timer_pkg::IDX_MODE, 8'h60, "mode bit3 zero");
    wr(prescaled_timer_pkg::IDX_MODE, 8'h07);
    rchk(prescaled_timer_pkg::IDX_MODE, 8'h60, "bad mode refused");
    // other modes are stored but do not count; cutoff also stops ticks
    wr(prescaled_timer_pkg::IDX_MODE, 8'h01);
    rchk(prescaled_timer_pkg::IDX_MODE, 8'h01, "other mode stored");
    wr(prescaled_timer_pkg::IDX_CTRL, 8'h01);
    repeat (10) @(posedge hclk);
    rchk(prescaled_timer_pkg::IDX_PRE, 8'hFF, "no count outside timer mode");
    wr(prescaled_timer_pkg::IDX_CTRL, 8'h00);
    wr(prescaled_timer_pkg::IDX_MODE, 8'h80);
    wr(prescaled_timer_pkg::IDX_CTRL, 8'h01);
    repeat (10) @(posedge hclk);
    rchk(prescaled_timer_pkg::IDX_PRE, 8'hFF, "cutoff stops count");
    wr(prescaled_timer_pkg::IDX_CTRL, 8'h00);
    wr(prescaled_timer_pkg::IDX_MODE, 8'h00);
  endtask

  // each source: period (2+1)*(1+1)=6 ticks times the source's cycles per tick
  task automatic t_sources();
    logic [2:0] srcs [6] = '{prescaled_timer_pkg::SRC_DIV1, prescaled_timer_pkg::SRC_DIV8,
      prescaled_timer_pkg::SRC_OSC, prescaled_timer_pkg::SRC_DIV2,
      prescaled_timer_pkg::SRC_SUB32, prescaled_timer_pkg::SRC_SUB};
    int gaps [6] = '{6, 48, 12, 12, 768, 24};
    int g;
    wr(prescaled_timer_pkg::IDX_PRE, 8'h02);
    wr(prescaled_timer_pkg::IDX_MAIN, 8'h01);
    rchk(prescaled_timer_pkg::IDX_PRE, 8'h02, "stopped prescale load");
    rchk(prescaled_timer_pkg::IDX_MAIN, 8'h01, "stopped main load");
    for (int i = 0; i < 6; i++) begin
      wr(prescaled_timer_pkg::IDX_MODE, {1'b0, srcs[i], 4'h0});
      wr(prescaled_timer_pkg::IDX_CTRL, 8'h01);
      irq_gap(g);
      chk(16'(g), 16'(gaps[i]), "underflow period");
      wr(prescaled_timer_pkg::IDX_CTRL, 8'h00);
    end
    wr(prescaled_timer_pkg::IDX_MODE, 8'h00);
  endtask

  task automatic t_flag();
    int g;
    wr(prescaled_timer_pkg::IDX_CTRL, 8'h01);
    irq_gap(g);
    rchk(prescaled_timer_pkg::IDX_CTRL, 8'h23, "running with flag");
    wr(prescaled_timer_pkg::IDX_CTRL, 8'h20);
    rchk(prescaled_timer_pkg::IDX_CTRL, 8'h20, "stopped, flag kept");
    wr(prescaled_timer_pkg::IDX_CTRL, 8'h00);
    rchk(prescaled_timer_pkg::IDX_CTRL, 8'h00, "flag cleared");
  endtask

  task automatic t_halt();
    logic [7:0] v;
    wr(prescaled_timer_pkg::IDX_CTRL, 8'h01);
    repeat (20) @(posedge hclk);
    wr(prescaled_timer_pkg::IDX_CTRL, 8'h04);
    bus(1'b0, prescaled_timer_pkg::IDX_CTRL, 8'h00, v);
    chk({8'h00, v & 8'hDF}, 16'h0, "halt clears run and status");
    rchk(prescaled_timer_pkg::IDX_PRE, 8'hFF, "halt prescale");
    rchk(prescaled_timer_pkg::IDX_MAIN, 8'hFF, "halt main");
    wr(prescaled_timer_pkg::IDX_CTRL, 8'h00);
  endtask

  // main write while counting waits for a prescaler underflow (every 256 ticks)
  task automatic t_live();
    logic [7:0] v;
    wr(prescaled_timer_pkg::IDX_CTRL, 8'h01);
    wr(prescaled_timer_pkg::IDX_MAIN, 8'h05);
    bus(1'b0, prescaled_timer_pkg::IDX_MAIN, 8'h00, v);
    chk({15'h0, (v === 8'hFF) | (v === 8'hFE)}, 16'h1, "main not loaded yet");
    repeat (300) @(posedge hclk);
    wr(prescaled_timer_pkg::IDX_CTRL, 8'h00);
    bus(1'b0, prescaled_timer_pkg::IDX_MAIN, 8'h00, v);
    chk({15'h0, (v === 8'h05) | (v === 8'h04)}, 16'h1, "main loaded at underflow");
    rchk(prescaled_timer_pkg::IDX_ROUTE, 8'h00, "route untouched");
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_route();
    t_mode();
    t_sources();
    t_flag();
    t_halt();
    t_live();
    stop_test();
  end
endmodule
